// [hdl/charger_readback_registers.sv]
// How it works
// - Three tri-state straps decode to a cell count 1..9 or 12, other listed codes read invalid.
// - A 5-bit read-only register shows the charge-current code applied to its DAC.
// - The applied charge-current code ramps one step at a time up on start and down on stop.
// - The commanded sense servo level is (code + 1) millivolts.
// - A 6-bit read-only register shows the charge-voltage code applied to its DAC.
// - A 6-bit read-only register shows the input-limit code, following the programmed setting.
// - A 16-bit register holds a filtered two's complement battery voltage.
// - A 16-bit register captures the battery current sample used in the last resistance calc.
// - A status bit reads one only while the measurement outputs are valid.
// - An invalid strap combination raises the live cell-count-error status bit.
// - The battery current word is signed, negative meaning discharge.
module charger_readback_registers
#(
  parameter int RAMP_CYC = readback_pkg::RAMP_STEP_CYC
)
(
  // Clock, reset, enable
  input  wire logic                                   i_ref_clk,
  input  wire logic                                   i_srst,
  input  wire logic                                   i_clk_en,
  // Cell-count straps (low/high/open codes)
  input  wire logic [1:0]                             i_count_strap_msb,
  input  wire logic [1:0]                             i_count_strap_mid,
  input  wire logic [1:0]                             i_count_strap_lsb,
  // Charger control inputs
  input  wire logic                                   i_charging,
  input  wire logic [readback_pkg::ICHG_W-1:0]        i_charge_current_goal,
  input  wire logic [readback_pkg::VCHG_W-1:0]        i_charge_voltage_target,
  input  wire logic [readback_pkg::IIN_W-1:0]         i_input_limit_setting,
  // Measurement inputs
  input  wire logic                                   i_vbat_sample_valid,
  input  wire logic signed [readback_pkg::MEAS_W-1:0] i_vbat_sample,
  input  wire logic signed [readback_pkg::MEAS_W-1:0] i_battery_current_result,
  input  wire logic                                   i_resistance_calc_done,
  input  wire logic                                   i_meas_outputs_valid,
  // Register read/write port
  input  wire logic [7:0]                             i_reg_addr,
  input  wire logic                                   i_reg_wr,
  input  wire logic [15:0]                            i_reg_wdata,
  output logic [15:0]                                 o_reg_rdata,
  // Live outputs
  output logic [readback_pkg::ICHG_W-1:0]             o_charge_current_dac_code,
  output logic [15:0]                                 o_servo_level_uv,
  output logic                                        o_cell_count_error
);

  // The ramp counter needs at least one cycle per code step
  if (RAMP_CYC < 1)
  begin
    $error("RAMP_CYC must be at least 1");
  end

  logic [readback_pkg::CELLS_W-1:0]      cells_next;
  logic                                  cells_bad;
  logic [readback_pkg::CELLS_W-1:0]      cell_count_readback_reg;
  logic [readback_pkg::ICHG_W-1:0]       charge_current_dac_code_reg;
  logic [readback_pkg::ICHG_W-1:0]       ramp_target;
  logic [readback_pkg::VCHG_W-1:0]       charge_voltage_dac_code_reg;
  logic [readback_pkg::IIN_W-1:0]        input_limit_dac_code_reg;
  logic signed [readback_pkg::MEAS_W-1:0] filtered_battery_voltage_reg;
  logic signed [readback_pkg::MEAS_W-1:0] resistance_calc_current_sample_reg;
  logic                                  measurement_valid_flag_reg;
  logic                                  filt_primed_reg;
  logic [31:0]                           ramp_cnt_reg;
  logic signed [readback_pkg::MEAS_W:0]  filt_diff;
  logic signed [readback_pkg::MEAS_W:0]  filt_sum;

  // Strap decode into cell count
  always_comb
  begin
    cells_bad  = 1'b0;
    cells_next = readback_pkg::CELLS_INVALID;
    case ({i_count_strap_msb, i_count_strap_mid, i_count_strap_lsb})
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_LOW, readback_pkg::STRAP_HIGH}:
        cells_next = 4'h1;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_HIGH, readback_pkg::STRAP_LOW}:
        cells_next = 4'h2;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_HIGH, readback_pkg::STRAP_HIGH}:
        cells_next = 4'h3;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_LOW, readback_pkg::STRAP_OPEN}:
        cells_next = 4'h4;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_OPEN, readback_pkg::STRAP_LOW}:
        cells_next = 4'h5;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_HIGH, readback_pkg::STRAP_OPEN}:
        cells_next = 4'h6;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_OPEN, readback_pkg::STRAP_HIGH}:
        cells_next = 4'h7;
      {readback_pkg::STRAP_LOW, readback_pkg::STRAP_OPEN, readback_pkg::STRAP_OPEN}:
        cells_next = 4'h8;
      {readback_pkg::STRAP_HIGH, readback_pkg::STRAP_LOW, readback_pkg::STRAP_LOW}:
        cells_next = 4'h9;
      {readback_pkg::STRAP_HIGH, readback_pkg::STRAP_HIGH, readback_pkg::STRAP_HIGH}:
        cells_next = readback_pkg::CELLS_TWELVE;
      default:
        cells_bad = 1'b1;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      cell_count_readback_reg <= readback_pkg::CELLS_INVALID;
      o_cell_count_error      <= 1'b0;
    end
    else if (i_clk_en)
    begin
      cell_count_readback_reg <= cells_next;
      o_cell_count_error      <= cells_bad;
    end
  end

  // Soft start/stop ramp of the applied current code
  assign ramp_target = i_charging ? i_charge_current_goal : '0;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      charge_current_dac_code_reg <= '0;
      ramp_cnt_reg                <= '0;
    end
    else if (i_clk_en)
    begin
      if (charge_current_dac_code_reg == ramp_target)
        ramp_cnt_reg <= '0;
      else if (ramp_cnt_reg >= 32'(RAMP_CYC - 1))
      begin
        ramp_cnt_reg <= '0;
        if (charge_current_dac_code_reg < ramp_target)
          charge_current_dac_code_reg <= charge_current_dac_code_reg + 5'h01;
        else
          charge_current_dac_code_reg <= charge_current_dac_code_reg - 5'h01;
      end
      else
        ramp_cnt_reg <= ramp_cnt_reg + 32'h00000001;
    end
  end

  assign o_charge_current_dac_code = charge_current_dac_code_reg;
  assign o_servo_level_uv = 16'((32'(charge_current_dac_code_reg) + 32'h1)
                                * readback_pkg::SERVO_STEP_UV);

  // DAC code captures
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      charge_voltage_dac_code_reg <= '0;
      input_limit_dac_code_reg    <= '0;
    end
    else if (i_clk_en)
    begin
      charge_voltage_dac_code_reg <= i_charge_voltage_target;
      input_limit_dac_code_reg    <= i_input_limit_setting;
    end
  end

  // Voltage filter: first sample loads directly, then y += (x - y) >>> n
  assign filt_diff = 17'(i_vbat_sample) - 17'(filtered_battery_voltage_reg);
  assign filt_sum  = 17'(filtered_battery_voltage_reg) + (filt_diff >>> readback_pkg::FILT_SHIFT);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      filtered_battery_voltage_reg <= readback_pkg::RESET_WORD;
      filt_primed_reg              <= 1'b0;
    end
    else if (i_clk_en && i_vbat_sample_valid)
    begin
      filt_primed_reg <= 1'b1;
      if (!filt_primed_reg)
        filtered_battery_voltage_reg <= i_vbat_sample;
      else
        filtered_battery_voltage_reg <= filt_sum[15:0];
    end
  end

  // Current sample used by the resistance calculation, kept signed
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      resistance_calc_current_sample_reg <= readback_pkg::RESET_WORD;
    else if (i_clk_en && i_resistance_calc_done)
      resistance_calc_current_sample_reg <= i_battery_current_result;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      measurement_valid_flag_reg <= 1'b0;
    else if (i_clk_en)
      measurement_valid_flag_reg <= i_meas_outputs_valid;
  end

  // Read mux; writes are never decoded
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_reg_rdata <= 16'h0000;
    else if (i_clk_en)
    begin
      o_reg_rdata <= 16'h0000;
      case (i_reg_addr)
        readback_pkg::OFS_CELLS:    o_reg_rdata <= {12'h000, cell_count_readback_reg};
        readback_pkg::OFS_ICHG_DAC: o_reg_rdata <= {11'h000, charge_current_dac_code_reg};
        readback_pkg::OFS_VCHG_DAC: o_reg_rdata <= {10'h000, charge_voltage_dac_code_reg};
        readback_pkg::OFS_IIN_DAC:  o_reg_rdata <= {10'h000, input_limit_dac_code_reg};
        readback_pkg::OFS_VBAT_FLT: o_reg_rdata <= filtered_battery_voltage_reg;
        readback_pkg::OFS_CUR_SMPL: o_reg_rdata <= resistance_calc_current_sample_reg;
        readback_pkg::OFS_VALID:    o_reg_rdata <= {15'h0000, measurement_valid_flag_reg};
        readback_pkg::OFS_SYS_STAT:
          o_reg_rdata <= 16'(o_cell_count_error) << readback_pkg::SYS_CELL_ERR_BIT;
        default:                    o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  logic unused_wr;
  assign unused_wr = i_reg_wr ^ (^i_reg_wdata);

endmodule

// [shared/readback_pkg.sv]
package readback_pkg;
  // Register sub-addresses
  localparam logic [7:0] OFS_CELLS    = 8'h43;
  localparam logic [7:0] OFS_ICHG_DAC = 8'h44;
  localparam logic [7:0] OFS_VCHG_DAC = 8'h45;
  localparam logic [7:0] OFS_IIN_DAC  = 8'h46;
  localparam logic [7:0] OFS_VBAT_FLT = 8'h47;
  localparam logic [7:0] OFS_CUR_SMPL = 8'h48;
  localparam logic [7:0] OFS_VALID    = 8'h4A;
  localparam logic [7:0] OFS_SYS_STAT = 8'h39;
  // Field positions and widths
  localparam int SYS_CELL_ERR_BIT = 8;
  localparam int VALID_BIT        = 0;
  localparam int CELLS_W          = 4;
  localparam int ICHG_W           = 5;
  localparam int VCHG_W           = 6;
  localparam int IIN_W            = 6;
  localparam int MEAS_W           = 16;
  // Reset values and the 12-cell code
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0]  CELLS_INVALID = 4'h0;
  localparam logic [3:0]  CELLS_TWELVE  = 4'hC;
  // Tri-state strap encodings
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;
  // Soft ramp step interval: 10 us per code step
  localparam int CLK_HZ       = 40000000;
  localparam int RAMP_STEP_US = 10;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_US * (CLK_HZ / 1000000)) < 1 ? 1
                               : RAMP_STEP_US * (CLK_HZ / 1000000);
  // Filter shift (exponential average weight 1/2^n)
  localparam int FILT_SHIFT = 3;
  // Servo level: (code + 1) * 1 mV, in microvolts
  localparam int SERVO_STEP_UV = 1000;
endpackage

// [verif/charger_readback_registers_assertions.sv]
module charger_readback_registers_assertions (
  input wire logic        i_ref_clk, i_srst, i_clk_en, i_charging,
  input wire logic [1:0]  i_count_strap_msb, i_count_strap_mid, i_count_strap_lsb,
  input wire logic [5:0]  i_input_limit_setting,
  input wire logic        i_meas_outputs_valid,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [15:0] o_reg_rdata,
  input wire logic [4:0]  o_charge_current_dac_code,
  input wire logic [15:0] o_servo_level_uv,
  input wire logic        o_cell_count_error
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [5:0] strap = {i_count_strap_msb, i_count_strap_mid, i_count_strap_lsb};
  wire logic [4:0] code = o_charge_current_dac_code;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst || !i_clk_en);
  AST_SERVO: assert property (o_servo_level_uv == (code + 16'h1) * 16'h3E8)
    else $error("servo level wrong");
  AST_RAMP_STEP: assert property (5'(code - $past(code)) inside {5'h0, 5'h1, 5'h1F})
    else $error("code jumped");
  AST_RAMP_IDLE: assert property (!i_charging && code == 5'h0 |=> code == 5'h0)
    else $error("code rose while idle");
  AST_CELL_BAD: assert property (strap inside {6'h00, 6'h11, 6'h14} |=> o_cell_count_error)
    else $error("cell error missing");
  AST_CELL_GOOD: assert property (strap == 6'h15 |=> !o_cell_count_error)
    else $error("cell error false");
  AST_CODE_READ: assert property (i_reg_addr == 8'h44 |=> o_reg_rdata == {11'h0, $past(code)})
    else $error("code readback wrong");
  AST_LIMIT_READ: assert property ($stable(i_input_limit_setting) && i_reg_addr == 8'h46
    |=> o_reg_rdata == {10'h0, $past(i_input_limit_setting)}) else $error("limit wrong");
  AST_VALID_LOW: assert property (!i_meas_outputs_valid ##1
    (!i_meas_outputs_valid && i_reg_addr == 8'h4A) |=> o_reg_rdata == 16'h0000)
    else $error("valid flag set");
  AST_VALID_HIGH: assert property (i_meas_outputs_valid ##1
    (i_meas_outputs_valid && i_reg_addr == 8'h4A) |=> o_reg_rdata == 16'h0001)
    else $error("valid flag clear");
  AST_UNMAPPED: assert property (i_reg_addr == 8'h49 |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  cover property (code == 5'h4 ##1 code == 5'h5);
  cover property (o_cell_count_error);
  cover property (i_reg_addr == 8'h4A ##1 o_reg_rdata == 16'h0001);
endmodule

// [verif/readback_host_model.sv]
module readback_host_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_reg_rdata,
  output logic      [7:0]  o_reg_addr = 8'h00,
  output logic             o_reg_wr = 1'b0,
  output logic      [15:0] o_reg_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Answer is taken at the edge after the address is sampled
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    repeat (2) @(posedge i_ref_clk);
    d = i_reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    o_reg_wr <= 1'b1;
    o_reg_wdata <= d;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b0;
  endtask
endmodule

// [verif/charger_readback_registers_test.sv]
module charger_readback_registers_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, chg = 1'b0, vs_v = 1'b0, rc_done = 1'b0, mv = 1'b0;
  logic [1:0] s2 = 2'h0, s1 = 2'h0, s0 = 2'h0;
  logic [5:0] vtgt = 6'h2A, ilim = 6'h3F;
  logic cen = 1'b1;
  logic [15:0] vsmp = 16'h0000, bat_cur = 16'h0000, wdata, rdata, servo, rd_v;
  logic [7:0] addr;
  logic [4:0] code;
  logic wr, cerr;
  int n_mismatch = 0, checks = 0;
  always #12.5 clk = ~clk;
  charger_readback_registers #(.RAMP_CYC(2)) dut_u (.i_ref_clk(clk), .i_srst(srst),
    .i_clk_en(cen), .i_count_strap_msb(s2), .i_count_strap_mid(s1), .i_count_strap_lsb(s0),
    .i_charging(chg), .i_charge_current_goal(5'h05), .i_charge_voltage_target(vtgt),
    .i_input_limit_setting(ilim), .i_vbat_sample_valid(vs_v), .i_vbat_sample(vsmp),
    .i_battery_current_result(bat_cur), .i_resistance_calc_done(rc_done),
    .i_meas_outputs_valid(mv), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_charge_current_dac_code(code), .o_servo_level_uv(servo),
    .o_cell_count_error(cerr));
  readback_host_model host_u (.i_ref_clk(clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
    .o_reg_wr(wr), .o_reg_wdata(wdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_cells;
    logic [9:0] tbl [14];
    tbl = '{10'h000, 10'h011, 10'h042, 10'h053, 10'h024, 10'h085, 10'h066, 10'h097,
            10'h0A8, 10'h109, 10'h110, 10'h140, 10'h3F0, 10'h15C};
    for (int k = 0; k < 14; k++)
    begin
      @(posedge clk);
      {s2, s1, s0} <= tbl[k][9:4];
      host_u.rd(8'h43, rd_v);
      check(rd_v, {12'h000, tbl[k][3:0]});
      host_u.rd(8'h39, rd_v);
      check(rd_v, {7'h00, tbl[k][3:0] == 4'h0, 8'h00});
      check({15'h0, cerr}, {15'h0, tbl[k][3:0] == 4'h0});
    end
    $display("cells done");
  endtask
  task automatic step_to(input logic [4:0] v);
    logic [4:0] prev;
    int n;
    prev = code;
    n = 0;
    while (code === prev && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({11'h0, code}, {11'h0, v});
    check(servo, (16'(v) + 16'h1) * 16'h3E8);
  endtask
  task automatic t_ramp;
    @(posedge clk);
    chg <= 1'b1;
    for (int i = 1; i <= 5; i++)
      step_to(5'(i));
    host_u.rd(8'h44, rd_v);
    check(rd_v, 16'h0005);
    chg <= 1'b0;
    for (int i = 4; i >= 0; i--)
      step_to(5'(i));
    $display("ramp done");
  endtask
  task automatic t_freeze;
    @(posedge clk);
    chg <= 1'b1;
    step_to(5'h01);
    @(posedge clk);
    cen <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({11'h0, code}, 16'h0001);
    @(posedge clk);
    cen <= 1'b1;
    step_to(5'h02);
    @(posedge clk);
    chg <= 1'b0;
    step_to(5'h01);
    step_to(5'h00);
    $display("freeze done");
  endtask
  task automatic t_regs;
    host_u.rd(8'h45, rd_v);
    check(rd_v, 16'h002A);
    host_u.wr(8'h46, 16'h0000);
    host_u.wr(8'h43, 16'hFFFF);
    host_u.rd(8'h46, rd_v);
    check(rd_v, 16'h003F);
    host_u.rd(8'h43, rd_v);
    check(rd_v, 16'h000C);
    host_u.rd(8'h49, rd_v);
    check(rd_v, 16'h0000);
    ilim <= 6'h15;
    host_u.rd(8'h46, rd_v);
    check(rd_v, 16'h0015);
    $display("regs done");
  endtask
  task automatic t_meas;
    logic [15:0] smp [2] = '{16'h8001, 16'h8009};
    logic [15:0] flt [2] = '{16'h8001, 16'h8002};
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      vsmp <= smp[i];
      vs_v <= 1'b1;
      @(posedge clk);
      vs_v <= 1'b0;
      host_u.rd(8'h47, rd_v);
      check(rd_v, flt[i]);
    end
    bat_cur <= 16'hFFFE;
    rc_done <= 1'b1;
    @(posedge clk);
    rc_done <= 1'b0;
    bat_cur <= 16'h0123;
    host_u.rd(8'h48, rd_v);
    check(rd_v, 16'hFFFE);
    host_u.rd(8'h4A, rd_v);
    check(rd_v, 16'h0000);
    mv <= 1'b1;
    host_u.rd(8'h4A, rd_v);
    check(rd_v, 16'h0001);
    $display("meas done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_cells;
    t_ramp;
    t_freeze;
    t_regs;
    t_meas;
    tally_and_finish;
  end
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
bind charger_readback_registers charger_readback_registers_assertions chk_u (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(i_clk_en), .i_charging(i_charging),
  .i_count_strap_msb(i_count_strap_msb), .i_count_strap_mid(i_count_strap_mid),
  .i_count_strap_lsb(i_count_strap_lsb), .i_input_limit_setting(i_input_limit_setting),
  .i_meas_outputs_valid(i_meas_outputs_valid), .i_reg_addr(i_reg_addr),
  .o_reg_rdata(o_reg_rdata), .o_charge_current_dac_code(o_charge_current_dac_code),
  .o_servo_level_uv(o_servo_level_uv), .o_cell_count_error(o_cell_count_error));
